// file: rtl/standby_mode_controller.sv
/*
  Standby mode controller: halt, deep stop and crystal-keep stop.
  Assumes wake sources are asynchronous levels, the request port comes
  from the core on the same clock, and osc_stable from the clock block.
*/
`timescale 1ns/1ps
module standby_mode_controller #(
  parameter int SETTLE_CNT = standby_pkg::SETTLE_CYCLES
) (
  input wire logic core_clk, // 40 MHz core clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [1:0] standby_req, // Entry request, one-cycle pulse
  input wire logic reset_pin_n, // Reset pin level, active low
  input wire logic wdt_lvd_reset, // Watchdog or low-voltage reset
  input wire logic ext_irq_line_a, // External line a request
  input wire logic ext_irq_line_b, // External line b request
  input wire logic ext_irq_line_c, // External line c request
  input wire logic ext_irq_line_e, // External line e request
  input wire logic ext_irq_line_f, // External line f request
  input wire logic line_a_level_mode, // Line a set to level detection
  input wire logic line_b_level_mode, // Line b set to level detection
  input wire logic port0_irq, // Port 0 request
  input wire logic base_timer_irq, // Base timer request
  input wire logic remote_rx_irq, // Remote receiver request
  input wire logic other_irq, // Any other interrupt request
  input wire logic crystal_running, // Crystal running before entry
  input wire logic osc_stable, // Restarted clock is stable
  output standby_pkg::gate_ctl_t gate_ctl, // Clock and execution gates
  output standby_pkg::mode_state_t mode // Current standby state
);

  standby_pkg::wake_src_t raw_src;
  standby_pkg::wake_src_t src;
  logic [1:0] mode_sync_raw;
  logic [1:0] mode_sync;
  logic stable_sync;
  logic any_irq;
  logic stop_wake;
  logic xtal_wake;
  logic crystal_kept;
  logic next_crystal_kept;
  logic [standby_pkg::CNT_W-1:0] settle;
  logic [standby_pkg::CNT_W-1:0] next_settle;
  standby_pkg::mode_state_t next_mode;
  standby_pkg::gate_ctl_t next_gate_ctl;

  // Settle count has reached its end point
  function automatic logic settle_done(input logic [standby_pkg::CNT_W-1:0] cnt);
    settle_done = (cnt >= standby_pkg::CNT_W'(SETTLE_CNT - 1));
  endfunction

  // Gather asynchronous wake sources for synchronising
  always_comb
  begin
    raw_src.sys_reset = ~reset_pin_n | wdt_lvd_reset;
    raw_src.ext_irq_line_a = ext_irq_line_a;
    raw_src.ext_irq_line_b = ext_irq_line_b;
    raw_src.ext_irq_line_c = ext_irq_line_c;
    raw_src.ext_irq_line_e = ext_irq_line_e;
    raw_src.ext_irq_line_f = ext_irq_line_f;
    raw_src.port0_irq = port0_irq;
    raw_src.base_timer_irq = base_timer_irq;
    raw_src.remote_rx_irq = remote_rx_irq;
    raw_src.other_irq = other_irq;
    mode_sync_raw = {line_b_level_mode, line_a_level_mode};
  end

  wake_sync #(
    .WIDTH($bits(standby_pkg::wake_src_t) + 3)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({raw_src, mode_sync_raw, osc_stable}),
    .sync_out({src, mode_sync, stable_sync})
  );

  // Wake qualification per state
  always_comb
  begin
    any_irq = src.ext_irq_line_a | src.ext_irq_line_b | src.ext_irq_line_c
      | src.ext_irq_line_e | src.ext_irq_line_f | src.port0_irq
      | src.base_timer_irq | src.remote_rx_irq | src.other_irq;
    stop_wake = (src.ext_irq_line_a & mode_sync[0])
      | (src.ext_irq_line_b & mode_sync[1])
      | src.ext_irq_line_c | src.ext_irq_line_e | src.ext_irq_line_f
      | src.port0_irq;
    xtal_wake = stop_wake | src.base_timer_irq | src.remote_rx_irq;
  end

  // Next state of the standby machine
  always_comb
  begin
    next_mode = mode;
    case (mode)
      standby_pkg::ST_RUN:
      begin
        if (standby_req == standby_pkg::REQ_HALT)
          next_mode = standby_pkg::ST_HALT;
        else if (standby_req == standby_pkg::REQ_DEEP_STOP)
          next_mode = standby_pkg::ST_DEEP_STOP;
        else if (standby_req == standby_pkg::REQ_XTAL_KEEP)
        begin
          next_mode = standby_pkg::ST_XTAL_KEEP;
        end
      end
      standby_pkg::ST_HALT:
        if (src.sys_reset || any_irq)
          next_mode = standby_pkg::ST_RUN;
      standby_pkg::ST_DEEP_STOP:
      begin
        if (src.sys_reset)
          next_mode = standby_pkg::ST_RUN;
        else if (stop_wake)
        begin
          next_mode = standby_pkg::ST_SETTLE;
        end
      end
      standby_pkg::ST_XTAL_KEEP:
      begin
        if (src.sys_reset)
          next_mode = standby_pkg::ST_RUN;
        else if (xtal_wake)
        begin
          next_mode = standby_pkg::ST_SETTLE;
        end
      end
      standby_pkg::ST_SETTLE:
      begin
        if (src.sys_reset)
          next_mode = standby_pkg::ST_RUN;
        else if (settle_done(settle) && stable_sync)
          next_mode = standby_pkg::ST_RUN;
      end
      default:
        next_mode = standby_pkg::ST_RUN;
    endcase
  end

  // Settle counter: cleared on entry to settle, stops at its end point
  always_comb
  begin
    next_settle = settle;
    if (next_mode == standby_pkg::ST_SETTLE && mode != standby_pkg::ST_SETTLE)
      next_settle = '0;
    else if (mode == standby_pkg::ST_SETTLE && !settle_done(settle))
      next_settle = settle + 1'b1;
  end

  // Settle counter register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      settle <= '0;
    else
      settle <= next_settle;
  end

  // Crystal condition captured on the edge that enters crystal-keep
  always_comb
  begin
    next_crystal_kept = crystal_kept;
    if (mode == standby_pkg::ST_RUN && next_mode == standby_pkg::ST_XTAL_KEEP)
      next_crystal_kept = crystal_running;
  end

  // Kept crystal condition register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      crystal_kept <= 1'b0;
    else
      crystal_kept <= next_crystal_kept;
  end

  // Gate outputs from the next state, so gates and mode change together
  always_comb
  begin
    next_gate_ctl = '1;
    case (next_mode)
      standby_pkg::ST_RUN:
        next_gate_ctl = '1;
      // Halt stops execution only; oscillators stay as they were
      standby_pkg::ST_HALT:
        next_gate_ctl.cpu_run = 1'b0;
      standby_pkg::ST_DEEP_STOP:
      begin
        next_gate_ctl.cpu_run = 1'b0;
        next_gate_ctl.periph_run = 1'b0;
        next_gate_ctl.base_timer_run = 1'b0;
        next_gate_ctl.ceramic_resonator_osc_en = 1'b0;
        next_gate_ctl.internal_rc_osc_en = 1'b0;
        next_gate_ctl.crystal_osc_en = 1'b0;
      end
      standby_pkg::ST_XTAL_KEEP:
      begin
        next_gate_ctl.cpu_run = 1'b0;
        next_gate_ctl.periph_run = 1'b0;
        next_gate_ctl.base_timer_run = 1'b1;
        next_gate_ctl.ceramic_resonator_osc_en = 1'b0;
        next_gate_ctl.internal_rc_osc_en = 1'b0;
        next_gate_ctl.crystal_osc_en = next_crystal_kept;
      end
      // Oscillators restart; execution waits for the settle count
      standby_pkg::ST_SETTLE:
      begin
        next_gate_ctl.cpu_run = 1'b0;
        next_gate_ctl.periph_run = 1'b0;
        next_gate_ctl.base_timer_run = 1'b0;
      end
      default:
        next_gate_ctl = '1;
    endcase
  end

  // State and gate registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode <= standby_pkg::ST_RUN;
      gate_ctl <= '1;
    end
    else
    begin
      mode <= next_mode;
      gate_ctl <= next_gate_ctl;
    end
  end

endmodule

// file: include/standby_pkg.sv
/*
  Shared constants, types and states for the standby mode controller.
  Assumes one 40 MHz core clock and an asynchronous active-low reset.
*/
package standby_pkg;

  localparam logic [1:0] REQ_NONE = 2'h0;
  localparam logic [1:0] REQ_HALT = 2'h1;
  localparam logic [1:0] REQ_DEEP_STOP = 2'h2;
  localparam logic [1:0] REQ_XTAL_KEEP = 2'h3;

  // Oscillator settle time in microseconds and its cycle count at 40 MHz
  localparam int SETTLE_US = 100;
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_DEEP_STOP,
    ST_XTAL_KEEP,
    ST_SETTLE
  } mode_state_t;

  // Wake sources, used raw and after synchronising to the core clock
  typedef struct packed {
    logic sys_reset;
    logic ext_irq_line_a;
    logic ext_irq_line_b;
    logic ext_irq_line_c;
    logic ext_irq_line_e;
    logic ext_irq_line_f;
    logic port0_irq;
    logic base_timer_irq;
    logic remote_rx_irq;
    logic other_irq;
  } wake_src_t;

  // Clock and execution gating outputs
  typedef struct packed {
    logic cpu_run;
    logic periph_run;
    logic base_timer_run;
    logic ceramic_resonator_osc_en;
    logic internal_rc_osc_en;
    logic crystal_osc_en;
  } gate_ctl_t;

endpackage

// file: rtl/wake_sync.sv
/*
  Two-flip-flop synchroniser for a vector of asynchronous levels.
  Assumes the inputs are levels held for more than two core clocks.
*/
`timescale 1ns/1ps
module wake_sync #(
  parameter int WIDTH = 10
) (
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Raw levels
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // Shift through the two stages
  always_comb
  begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule

// file: sim/osc_clock_model.sv
/* Clock block model: reports stability after restart.
   Assumes the controller gate struct and one core clock. */
`timescale 1ns/1ps
module osc_clock_model #(
  parameter int DELAY = 6
) (
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Reset, active low
  input wire standby_pkg::gate_ctl_t gate_ctl, // Gates
  output logic osc_stable // Clock stable
);
  int cnt;
  // Stable out of reset, and after a restart once the fast oscillators ran DELAY cycles
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      cnt <= DELAY;
    else if (!(gate_ctl.ceramic_resonator_osc_en && gate_ctl.internal_rc_osc_en))
      cnt <= 0;
    else if (cnt < DELAY)
      cnt <= cnt + 1;
  assign osc_stable = cnt >= DELAY;
endmodule

// file: sim/standby_mode_controller_checker.sv
/* Port assertions for the standby controller.
   Bound to the controller; sees its ports only. */
`timescale 1ns/1ps
module standby_mode_controller_checker (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic [1:0] standby_req, // Request
  input wire logic other_irq, // Other irq
  input wire logic port0_irq, // Port 0 irq
  input wire logic base_timer_irq, // Timer irq
  input wire logic crystal_running, // Crystal state
  input wire standby_pkg::gate_ctl_t gate_ctl, // Gates
  input wire standby_pkg::mode_state_t mode // State
);
  logic in_run, in_halt, in_deep, in_xk, in_set;
  // State decodes
  assign in_run = mode == standby_pkg::ST_RUN;
  assign in_halt = mode == standby_pkg::ST_HALT;
  assign in_deep = mode == standby_pkg::ST_DEEP_STOP;
  assign in_xk = mode == standby_pkg::ST_XTAL_KEEP;
  assign in_set = mode == standby_pkg::ST_SETTLE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  halt_exec_a: assert property (in_halt |-> !gate_ctl.cpu_run && gate_ctl.periph_run)
    else $error("halt gates");
  halt_osc_a: assert property (in_halt && $past(in_run) |-> gate_ctl[2:0] == $past(gate_ctl[2:0]))
    else $error("halt osc");
  deep_gates_a: assert property (in_deep |-> gate_ctl == 6'h00)
    else $error("deep gates");
  xk_gates_a: assert property (in_xk |-> gate_ctl[5:1] == 5'h04)
    else $error("xk gates");
  xk_crystal_a: assert property (in_run && standby_req == 2'h3 |=> gate_ctl[0] == $past(crystal_running))
    else $error("xk crystal");
  enter_halt_a: assert property (in_run && standby_req == 2'h1 |=> in_halt)
    else $error("halt entry");
  halt_wake_a: assert property (in_halt && other_irq |-> ##[1:3] in_run)
    else $error("halt wake");
  deep_wake_a: assert property (in_deep && port0_irq |-> ##[1:3] in_set)
    else $error("deep wake");
  xk_wake_a: assert property (in_xk && base_timer_irq |-> ##[1:3] in_set)
    else $error("xk wake");
  cover property (in_halt ##1 in_run);
  cover property (in_deep ##1 in_set);
  cover property (in_xk ##1 in_set);
endmodule
bind standby_mode_controller standby_mode_controller_checker chk_u (.core_clk, .reset_n, .standby_req,
  .other_irq, .port0_irq, .base_timer_irq, .crystal_running, .gate_ctl, .mode);

// file: sim/standby_mode_controller_tb_top.sv
/* Standby controller bench: one task per scenario.
   Needs the controller, the clock model and the checker. */
`timescale 1ns/1ps
module standby_mode_controller_tb_top;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] standby_req = 2'h0;
  logic [10:0] src = 11'h0; // Pin,wdt,a,b,c,e,f,p0,bt,rm,other
  logic [1:0] lvl = 2'h0;
  logic crystal_running = 1'b0;
  logic osc_stable;
  standby_pkg::gate_ctl_t gate_ctl;
  standby_pkg::mode_state_t mode;
  int errors = 0;
  int cmp_count = 0;
  int dr[5] = '{8, 7, 2, 1, 0};
  int ds[6] = '{8, 7, 6, 5, 4, 3};
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  standby_mode_controller #(.SETTLE_CNT(4)) dut_u (.core_clk, .reset_n, .standby_req, .reset_pin_n(~src[10]),
    .wdt_lvd_reset(src[9]), .ext_irq_line_a(src[8]), .ext_irq_line_b(src[7]), .ext_irq_line_c(src[6]),
    .ext_irq_line_e(src[5]), .ext_irq_line_f(src[4]), .line_a_level_mode(lvl[0]), .line_b_level_mode(lvl[1]),
    .port0_irq(src[3]), .base_timer_irq(src[2]), .remote_rx_irq(src[1]), .other_irq(src[0]),
    .crystal_running, .osc_stable, .gate_ctl, .mode);
  osc_clock_model #(.DELAY(6)) osc_u (.core_clk, .reset_n, .gate_ctl, .osc_stable);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic enter(input logic [1:0] r);
    @(negedge core_clk) standby_req = r;
    @(negedge core_clk) standby_req = 2'h0;
  endtask
  task automatic wait_mode(input standby_pkg::mode_state_t m, input int lim);
    for (int n = 0; n < lim && mode !== m; n++)
      @(negedge core_clk);
  endtask
  // Raise one source, expect state m, then back to run
  task automatic wake(input int i, input standby_pkg::mode_state_t m);
    @(negedge core_clk) src[i] = 1'b1;
    wait_mode(m, 6);
    check("wake state", 8'(mode), 8'(m));
    @(negedge core_clk) src[i] = 1'b0;
    wait_mode(standby_pkg::ST_RUN, 40);
    check("resumed", 8'(gate_ctl[5:4]), 8'h3);
  endtask
  // Raise one source that must be ignored
  task automatic stay(input int i, input standby_pkg::mode_state_t m);
    @(negedge core_clk) src[i] = 1'b1;
    repeat (6) @(negedge core_clk);
    check("ignored", 8'(mode), 8'(m));
    src[i] = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic t_halt;
    check("reset gates", 8'(gate_ctl), 8'h3f);
    enter(2'h1);
    check("halt gates", 8'(gate_ctl), 8'h1f);
    enter(2'h2);
    check("halt refuse", 8'(mode), 8'(standby_pkg::ST_HALT));
    wake(0, standby_pkg::ST_RUN);
    enter(2'h1);
    wake(9, standby_pkg::ST_RUN);
    enter(2'h1);
    wake(10, standby_pkg::ST_RUN);
    $display("halt test done");
  endtask
  task automatic t_deep;
    enter(2'h2);
    check("deep gates", 8'(gate_ctl), 8'h00);
    foreach (dr[k])
      stay(dr[k], standby_pkg::ST_DEEP_STOP);
    lvl = 2'h3;
    foreach (ds[k])
    begin
      if (k > 0)
        enter(2'h2);
      wake(ds[k], standby_pkg::ST_SETTLE);
    end
    enter(2'h2);
    wake(9, standby_pkg::ST_RUN);
    $display("deep test done");
  endtask
  task automatic t_xtal;
    lvl = 2'h0;
    for (int c = 0; c < 2; c++)
    begin
      crystal_running = c[0];
      enter(2'h3);
      check("xk gates", 8'(gate_ctl), {7'h04, c[0]});
      wake(2 - c, standby_pkg::ST_SETTLE);
    end
    enter(2'h3);
    stay(7, standby_pkg::ST_XTAL_KEEP);
    wake(6, standby_pkg::ST_SETTLE);
    enter(2'h3);
    wake(10, standby_pkg::ST_RUN);
    $display("xtal test done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    t_halt();
    t_deep();
    t_xtal();
    tally_and_finish();
  end
  // Watchdog well past the expected run
  initial
  begin
    #(4000 * 25);
    errors++;
    tally_and_finish();
  end
endmodule
